// ===== hw/dbs_clock_sel.sv
// Purpose: Builds the switching clock and the follower clock output.
// Assumes: Sync pin and oscillator tick are synchronous to core_clk.
// Notes: An external clock that stops for LOSS_CYC cycles falls back.
`timescale 1ns/1ps
module dbs_clock_sel #(
	parameter int LOSS_CYC = 64
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic osc_tick,
	input wire logic sync_in,
	input wire logic sync_tied_rail,
	output logic sw_clk,
	output logic sw_rise,
	output logic sw_fall,
	output logic follower_clock_out,
	output logic ext_active
);
	logic sync_q;
	logic ext_q;
	logic [15:0] idle_q;
	logic div_q;
	logic [15:0] cyc_q;
	logic [15:0] tper_q;
	logic tick_mid;
	logic fco_q;
	logic src_tick;
	logic sync_rise;
	assign sync_rise = sync_in && !sync_q;
	// LOSS_CYC cycles without an external edge hand the rate back to the oscillator.
	assign src_tick = ext_q ? sync_rise : osc_tick;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_q <= 1'b0;
			ext_q <= 1'b0;
			idle_q <= 16'h0000;
		end else if (clk_en) begin
			sync_q <= sync_in;
			if (sync_rise && !sync_tied_rail) begin
				ext_q <= 1'b1;
				idle_q <= 16'h0000;
			end else if (idle_q >= 16'(LOSS_CYC)) begin
				ext_q <= 1'b0;
			end else begin
				idle_q <= idle_q + 16'h0001;
			end
		end
	end
	// The switching clock is the source divided by two.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_q <= 1'b0;
		end else if (clk_en && src_tick) begin
			div_q <= !div_q;
		end
	end
	// Source tick spacing is measured so the double-rate clock can rise
	// halfway between ticks, a quarter switching period after channel one.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cyc_q <= 16'h0000;
			tper_q <= 16'h0000;
		end else if (clk_en) begin
			if (src_tick) begin
				tper_q <= cyc_q + 16'h0001;
				cyc_q <= 16'h0000;
			end else begin
				cyc_q <= cyc_q + 16'h0001;
			end
		end
	end
	assign tick_mid = (cyc_q + 16'h0001) == (tper_q >> 1);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fco_q <= 1'b0;
		end else if (clk_en) begin
			if (sync_tied_rail && !ext_q) begin
				if (src_tick) begin
					fco_q <= 1'b0;
				end else if (tick_mid) begin
					fco_q <= 1'b1;
				end
			end else if (src_tick) begin
				fco_q <= !div_q;
			end
		end
	end
	assign sw_clk = div_q;
	assign sw_rise = clk_en && src_tick && !div_q;
	assign sw_fall = clk_en && src_tick && div_q;
	assign follower_clock_out = fco_q;
	assign ext_active = ext_q;
endmodule

// ===== hw/dbs_phase.sv
// Purpose: One channel's gate-drive timing with dead time and cycle skip.
// Assumes: Start pulses arrive once per switching period.
// Notes: The duty request is in eighths and is capped at seven.
`timescale 1ns/1ps
module dbs_phase #(
	parameter int PER_W = 16
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic start,
	input wire logic run,
	input wire logic over_limit,
	input wire logic [2:0] duty_req,
	output logic high_side_drive,
	output logic low_side_drive
);
	logic [PER_W-1:0] per_q;
	logic [PER_W-1:0] cnt_q;
	logic [PER_W-1:0] on_len;
	logic hs_q;
	logic [3:0] dead_q;
	logic [2:0] duty;
	assign duty = (duty_req > 3'(dbs_pkg::DUTY_NUM)) ?
		3'(dbs_pkg::DUTY_NUM) : duty_req;
	assign on_len = PER_W'((per_q * duty) / dbs_pkg::DUTY_DEN);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			per_q <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (start) begin
				// The start edge itself belongs to the period just ended.
				per_q <= cnt_q + PER_W'(1);
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + PER_W'(1);
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hs_q <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				hs_q <= 1'b0;
			end else if (start) begin
				hs_q <= !over_limit && duty != 3'h0;
			end else if (cnt_q + PER_W'(1) >= on_len) begin
				hs_q <= 1'b0;
			end
		end
	end
	// Low side waits out the dead time after the high side drops.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dead_q <= 4'h0;
		end else if (clk_en) begin
			if (hs_q) begin
				dead_q <= 4'(dbs_pkg::DEAD_CYC);
			end else if (dead_q != 4'h0) begin
				dead_q <= dead_q - 4'h1;
			end
		end
	end
	assign high_side_drive = hs_q;
	assign low_side_drive = !hs_q && dead_q == 4'h0;
endmodule

// ===== hw/dbs_pkg.sv
// Purpose: Shared constants for the dual buck sequencing and sync block.
// Assumes: One core clock at 250 MHz; analog decisions arrive as logic levels.
// Notes: Timing counts are derived from printed times and the clock rate.
package dbs_pkg;
	localparam int CLK_MHZ = 250;
	localparam int DEAD_TIME_NS = 30;
	// A least time rounds up to whole cycles.
	localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SS_CYCLES = 1024;
	localparam int DAC_STEPS = 64;
	localparam int DAC_W = 6;
	localparam int STEP_CYCLES = SS_CYCLES / DAC_STEPS;
	localparam int STEP_W = 4;
	// Duty ceiling of 0.875 expressed in eighths of the period.
	localparam int DUTY_NUM = 7;
	localparam int DUTY_DEN = 8;
	// Current-limit pin divider and values in millivolts.
	localparam int CURRENT_LIMIT_SET_DIV = 10;
	localparam int CURRENT_LIMIT_SET_DEFAULT_MV = 100;
	localparam int CURRENT_LIMIT_SET_MIN_MV = 50;
	localparam int CURRENT_LIMIT_SET_MAX_MV = 300;
	localparam int MV_W = 12;
	localparam logic [DAC_W-1:0] DAC_TOP = 6'h3F;
	localparam logic [DAC_W-1:0] DAC_ZERO = 6'h00;
	typedef enum logic [1:0] {
		DBS_SYNC_GND,
		DBS_SYNC_RAIL,
		DBS_SYNC_EXT
	} dbs_sync_mode_t;
	typedef enum logic [2:0] {
		DBS_OFF,
		DBS_RAMP_UP,
		DBS_RUN,
		DBS_RAMP_DOWN
	} dbs_seq_t;
endpackage

// ===== hw/dbs_top.sv
// Purpose: Sequencing, protection and clocking of a dual step-down control.
// Assumes: Comparator decisions are logic levels synchronous to core_clk.
// Notes: Supply and thermal thresholds are decided outside; current limit is compared here in millivolts.
`timescale 1ns/1ps
module dbs_top #(
	parameter int LOSS_CYC = 64,
	parameter int PER_W = 16
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic rail_good,
	input wire logic over_temp,
	input wire logic enable,
	input wire logic osc_tick,
	input wire logic sync_in,
	input wire logic sync_tied_rail,
	input wire logic limit_pin_at_rail,
	input wire logic [dbs_pkg::MV_W-1:0] limit_pin_mv,
	input wire logic [dbs_pkg::MV_W-1:0] sense_one_mv,
	input wire logic [dbs_pkg::MV_W-1:0] sense_two_mv,
	input wire logic [2:0] duty_one,
	input wire logic [2:0] duty_two,
	input wire logic out_one_good,
	input wire logic out_two_good,
	output logic high_side_drive_one,
	output logic low_side_drive_one,
	output logic high_side_drive_two,
	output logic low_side_drive_two,
	output logic hs_to_switch_node,
	output logic error_amp_discharge,
	output logic rail_keep_on,
	output logic datum_keep_on,
	output logic [dbs_pkg::DAC_W-1:0] ref_dac,
	output logic reset_n_o,
	output logic reset_n_oe,
	output logic follower_clock_out,
	output logic ext_clock_active,
	output logic soft_start_done
);
	dbs_pkg::dbs_seq_t seq_q;
	logic en_q;
	logic [dbs_pkg::DAC_W-1:0] dac_q;
	logic [dbs_pkg::STEP_W-1:0] step_q;
	logic ss_done_q;
	logic lockout;
	logic fault;
	logic [dbs_pkg::MV_W-1:0] thresh_mv;
	logic [dbs_pkg::MV_W-1:0] adj_mv;
	logic over_one;
	logic over_two;
	logic sw_clk;
	logic sw_rise;
	logic sw_fall;
	logic run;
	logic hs1;
	logic ls1;
	logic hs2;
	logic ls2;
	logic rst_low;

	assign lockout = !rail_good;
	assign fault = lockout || over_temp;

	// Threshold selection: rail tie overrides the scaled pin voltage.
	assign adj_mv = dbs_pkg::MV_W'(limit_pin_mv / dbs_pkg::CURRENT_LIMIT_SET_DIV);
	always_comb begin
		if (limit_pin_at_rail) begin
			thresh_mv = dbs_pkg::MV_W'(dbs_pkg::CURRENT_LIMIT_SET_DEFAULT_MV);
		end else if (adj_mv < dbs_pkg::MV_W'(dbs_pkg::CURRENT_LIMIT_SET_MIN_MV)) begin
			thresh_mv = dbs_pkg::MV_W'(dbs_pkg::CURRENT_LIMIT_SET_MIN_MV);
		end else if (adj_mv > dbs_pkg::MV_W'(dbs_pkg::CURRENT_LIMIT_SET_MAX_MV)) begin
			thresh_mv = dbs_pkg::MV_W'(dbs_pkg::CURRENT_LIMIT_SET_MAX_MV);
		end else begin
			thresh_mv = adj_mv;
		end
	end
	assign over_one = sense_one_mv > thresh_mv;
	assign over_two = sense_two_mv > thresh_mv;

	dbs_clock_sel #(
		.LOSS_CYC(LOSS_CYC)
	) u_clk (
		.core_clk(core_clk),
		.srst(srst),
		.clk_en(clk_en),
		.osc_tick(osc_tick),
		.sync_in(sync_in),
		.sync_tied_rail(sync_tied_rail),
		.sw_clk(sw_clk),
		.sw_rise(sw_rise),
		.sw_fall(sw_fall),
		.follower_clock_out(follower_clock_out),
		.ext_active(ext_clock_active)
	);

	// Sequencer: a fault restarts everything from the off state.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			seq_q <= dbs_pkg::DBS_OFF;
			en_q <= 1'b0;
		end else if (clk_en) begin
			en_q <= enable;
			if (fault) begin
				seq_q <= dbs_pkg::DBS_OFF;
				en_q <= 1'b0;
			end else begin
				case (seq_q)
				dbs_pkg::DBS_OFF: begin
					if (enable && !en_q) begin
						seq_q <= dbs_pkg::DBS_RAMP_UP;
					end
				end
				dbs_pkg::DBS_RAMP_UP: begin
					if (!enable) begin
						seq_q <= dbs_pkg::DBS_RAMP_DOWN;
					end else if (ss_done_q) begin
						seq_q <= dbs_pkg::DBS_RUN;
					end
				end
				dbs_pkg::DBS_RUN: begin
					if (!enable) begin
						seq_q <= dbs_pkg::DBS_RAMP_DOWN;
					end
				end
				dbs_pkg::DBS_RAMP_DOWN: begin
					if (dac_q == dbs_pkg::DAC_ZERO && sw_rise &&
						step_q == '1) begin
						seq_q <= dbs_pkg::DBS_OFF;
					end
				end
				default: begin
					seq_q <= dbs_pkg::DBS_OFF;
				end
				endcase
			end
		end
	end

	// Ramp: one DAC step per sixteen switching cycles each way.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dac_q <= dbs_pkg::DAC_ZERO;
			step_q <= '0;
			ss_done_q <= 1'b0;
		end else if (clk_en) begin
			if (fault || seq_q == dbs_pkg::DBS_OFF) begin
				dac_q <= dbs_pkg::DAC_ZERO;
				step_q <= '0;
				ss_done_q <= 1'b0;
			end else if (sw_rise) begin
				step_q <= step_q + dbs_pkg::STEP_W'(1);
				if (step_q == '1) begin
					if (seq_q == dbs_pkg::DBS_RAMP_UP) begin
						if (dac_q == dbs_pkg::DAC_TOP) begin
							ss_done_q <= 1'b1;
						end else begin
							dac_q <= dac_q + dbs_pkg::DAC_W'(1);
						end
					end else if (seq_q == dbs_pkg::DBS_RAMP_DOWN &&
						dac_q != dbs_pkg::DAC_ZERO) begin
						dac_q <= dac_q - dbs_pkg::DAC_W'(1);
					end
				end
			end
			if (seq_q == dbs_pkg::DBS_RAMP_DOWN) begin
				ss_done_q <= 1'b0;
			end
		end
	end

	assign run = !fault && seq_q != dbs_pkg::DBS_OFF;

	dbs_phase #(
		.PER_W(PER_W)
	) u_ch_one (
		.core_clk(core_clk),
		.srst(srst),
		.clk_en(clk_en),
		.start(sw_rise),
		.run(run),
		.over_limit(over_one),
		.duty_req(duty_one),
		.high_side_drive(hs1),
		.low_side_drive(ls1)
	);

	dbs_phase #(
		.PER_W(PER_W)
	) u_ch_two (
		.core_clk(core_clk),
		.srst(srst),
		.clk_en(clk_en),
		.start(sw_fall),
		.run(run),
		.over_limit(over_two),
		.duty_req(duty_two),
		.high_side_drive(hs2),
		.low_side_drive(ls2)
	);

	// Lockout holds the low side on; thermal fault and shutdown release it.
	always_comb begin
		high_side_drive_one = 1'b0;
		high_side_drive_two = 1'b0;
		low_side_drive_one = 1'b0;
		low_side_drive_two = 1'b0;
		if (lockout) begin
			low_side_drive_one = 1'b1;
			low_side_drive_two = 1'b1;
		end else if (!over_temp && run) begin
			high_side_drive_one = hs1;
			low_side_drive_one = ls1;
			high_side_drive_two = hs2;
			low_side_drive_two = ls2;
		end
	end

	// Shutdown parks the gates so the switch node floats.
	assign hs_to_switch_node = !lockout && seq_q == dbs_pkg::DBS_OFF;
	assign error_amp_discharge = seq_q == dbs_pkg::DBS_OFF;
	assign rail_keep_on = 1'b1;
	assign datum_keep_on = 1'b1;
	assign ref_dac = dac_q;
	assign soft_start_done = ss_done_q;

	// Open drain: output value is always low, the enable does the work.
	assign rst_low = lockout || over_temp || !ss_done_q ||
		!out_one_good || !out_two_good;
	assign reset_n_o = 1'b0;
	assign reset_n_oe = rst_low;

	chk_lockout_gates: assert property (@(posedge core_clk) disable iff (srst)
		lockout |-> (!high_side_drive_one && low_side_drive_one
		&& !high_side_drive_two && low_side_drive_two))
		else $error("Lockout did not park the gates.");
	chk_lockout_reset: assert property (@(posedge core_clk) disable iff (srst)
		lockout |-> reset_n_oe)
		else $error("Reset not pulled during lockout.");
	chk_reset_release: assert property (@(posedge core_clk) disable iff (srst)
		!reset_n_oe |-> (ss_done_q && out_one_good && out_two_good))
		else $error("Reset released too early.");
	chk_no_overlap: assert property (@(posedge core_clk) disable iff (srst)
		!(high_side_drive_one && low_side_drive_one))
		else $error("Channel one drives overlap.");
	chk_temp_drives: assert property (@(posedge core_clk) disable iff (srst)
		over_temp && !lockout |-> !high_side_drive_one && !low_side_drive_two
		&& reset_n_oe)
		else $error("Thermal fault left drives or reset active.");
	chk_enable_start: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && !fault && seq_q == dbs_pkg::DBS_OFF && enable && !en_q
		|=> seq_q == dbs_pkg::DBS_RAMP_UP)
		else $error("Enable edge did not start soft-start.");
	chk_stop_ramp: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && !fault && seq_q == dbs_pkg::DBS_RUN && !enable
		|=> seq_q == dbs_pkg::DBS_RAMP_DOWN)
		else $error("Enable fall did not start soft-stop.");
	chk_off_at_zero: assert property (@(posedge core_clk) disable iff (srst)
		!fault && $past(seq_q) == dbs_pkg::DBS_RAMP_DOWN
		&& seq_q == dbs_pkg::DBS_OFF |-> $past(dac_q) == dbs_pkg::DAC_ZERO)
		else $error("Shutdown entered before ramp end.");
	chk_skip_cycle: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && sw_rise && over_one |=> !hs1)
		else $error("Cycle not skipped over current limit.");
	cov_soft_start: cover property (@(posedge core_clk)
		seq_q == dbs_pkg::DBS_RAMP_UP ##1 seq_q == dbs_pkg::DBS_RUN);
	cov_soft_stop: cover property (@(posedge core_clk)
		seq_q == dbs_pkg::DBS_RAMP_DOWN ##1 seq_q == dbs_pkg::DBS_OFF);
	cov_ext_clock: cover property (@(posedge core_clk) ext_clock_active);
endmodule

// ===== testbench/dbs_stage_model.sv
// Purpose: Oscillator and power stage model on the far side of the block.
// Assumes: Outputs track the reference DAC while the sequencer runs.
// Notes: Good flags need 58 of 64 steps, just above 90 percent.
`timescale 1ns/1ps
module dbs_stage_model #(
	parameter int OSC_CYC = 8
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [dbs_pkg::DAC_W-1:0] ref_dac,
	input wire logic sag_one,
	output logic osc_tick,
	output logic out_one_good,
	output logic out_two_good
);
	int cnt_q;
	// The timing resistor is set for half the rate of the bench's sync clock.
	always_ff @(posedge core_clk) begin
		if (srst || cnt_q == OSC_CYC - 1) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign osc_tick = (cnt_q == OSC_CYC - 1);
	assign out_two_good = (ref_dac >= 6'h3A);
	assign out_one_good = (ref_dac >= 6'h3A) && !sag_one;
endmodule

// ===== testbench/dual_buck_sequencing_and_sync_bench.sv
// Purpose: Self-checking bench for the dual buck sequencing and sync block.
// Assumes: Oscillator ticks every 8 cycles, so one switching period is 16.
// Notes: Loss of sync is cut to 16 cycles to keep the run short.
`timescale 1ns/1ps
module dual_buck_sequencing_and_sync_bench;
	localparam int PER = 16;
	localparam int LOSS = 16;
	localparam int STEP = 16 * PER;
	localparam int SS_CYC = dbs_pkg::SS_CYCLES * PER;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic rail_good = 1'b0;
	logic over_temp = 1'b0;
	logic enable = 1'b0;
	logic sync_in = 1'b0;
	logic sync_tied_rail = 1'b0;
	logic at_rail = 1'b1;
	logic [dbs_pkg::MV_W-1:0] pin_mv = 12'h000;
	logic [dbs_pkg::MV_W-1:0] sense_mv = 12'h000;
	logic [2:0] duty_one = 3'h2;
	logic sag_one = 1'b0;
	logic sync_run = 1'b0;
	logic sync_ph = 1'b0;
	logic osc_tick, good_one, good_two;
	logic hs1, ls1, hs2, ls2, hs_to_sw, ea_dis, rail_on, datum_on;
	logic [dbs_pkg::DAC_W-1:0] ref_dac;
	logic rst_o, rst_oe, fclk, ext_on, ss_done;
	int errors = 0;
	int checks_done = 0;
	dbs_top #(.LOSS_CYC(LOSS), .PER_W(16)) i_dbs_top (
		.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
		.rail_good(rail_good), .over_temp(over_temp), .enable(enable),
		.osc_tick(osc_tick), .sync_in(sync_in),
		.sync_tied_rail(sync_tied_rail), .limit_pin_at_rail(at_rail),
		.limit_pin_mv(pin_mv), .sense_one_mv(sense_mv),
		.sense_two_mv(12'h000), .duty_one(duty_one), .duty_two(3'h3),
		.out_one_good(good_one), .out_two_good(good_two),
		.high_side_drive_one(hs1), .low_side_drive_one(ls1),
		.high_side_drive_two(hs2), .low_side_drive_two(ls2),
		.hs_to_switch_node(hs_to_sw), .error_amp_discharge(ea_dis),
		.rail_keep_on(rail_on), .datum_keep_on(datum_on),
		.ref_dac(ref_dac), .reset_n_o(rst_o), .reset_n_oe(rst_oe),
		.follower_clock_out(fclk), .ext_clock_active(ext_on),
		.soft_start_done(ss_done));
	dbs_stage_model #(.OSC_CYC(PER / 2)) i_dbs_stage_model (
		.core_clk(core_clk), .srst(srst), .ref_dac(ref_dac),
		.sag_one(sag_one), .osc_tick(osc_tick),
		.out_one_good(good_one), .out_two_good(good_two));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// Sync rises every 4 cycles, twice the oscillator rate.
	always @(posedge core_clk) begin
		#1;
		if (sync_run) begin
			sync_ph = ~sync_ph;
			if (sync_ph) begin
				sync_in = ~sync_in;
			end
		end
	end
	always @(posedge core_clk) begin
		if (!srst && ((hs1 && ls1) || (hs2 && ls2))) begin
			errors++;
			$display("CHECK FAILED cross conduction expected 0 seen 1");
		end
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		give_verdict();
	end
	task automatic give_verdict();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic check_bit(input string what, input logic exp,
		input logic got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_num(input string what, input int lo, input int hi,
		input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
				hi, got);
		end
	endtask
	function automatic logic sel(input int which);
		return which == 0 ? fclk : (which == 1 ? hs1 : hs2);
	endfunction
	task automatic wait_rise(input int which, output int n);
		logic prev;
		n = 0;
		do begin
			prev = sel(which);
			tick(1);
			n++;
		end while (n < 400 && !(prev === 1'b0 && sel(which) === 1'b1));
	endtask
	task automatic gap_of(input int which, output int n);
		wait_rise(which, n);
		wait_rise(which, n);
	endtask
	task automatic t_lockout();
		rail_good = 1'b0;
		tick(3);
		check_bit("lockout low side", 1'b1, ls1 & ls2);
		check_bit("lockout high side", 1'b0, hs1 | hs2);
		check_bit("lockout reset pin", 1'b1, rst_oe);
		check_bit("reset drive level", 1'b0, rst_o);
	endtask
	task automatic t_shutdown();
		rail_good = 1'b1;
		tick(3);
		check_bit("sw node tie", 1'b1, hs_to_sw);
		check_bit("comp discharge", 1'b1, ea_dis);
		check_bit("off drives", 1'b0, hs1 | ls1 | hs2 | ls2);
		check_bit("rail and datum", 1'b1, rail_on & datum_on);
	endtask
	task automatic t_soft_start();
		int n;
		int s;
		enable = 1'b1;
		n = 0;
		s = 0;
		while (ref_dac !== 6'h01 && n < 2 * STEP) begin
			tick(1);
			n++;
		end
		while (ref_dac === 6'h01 && s < 2 * STEP) begin
			tick(1);
			s++;
		end
		check_num("dac step", STEP, STEP, s);
		check_bit("sw node free", 1'b0, hs_to_sw);
		check_bit("reset in ramp", 1'b1, rst_oe);
		n = n + s;
		while (ss_done !== 1'b1 && n < SS_CYC + 2 * STEP) begin
			tick(1);
			n++;
		end
		check_num("soft start time", SS_CYC - PER, SS_CYC + PER, n);
		check_bit("dac top", 1'b1, ref_dac === dbs_pkg::DAC_TOP);
		check_bit("reset released", 1'b0, rst_oe);
	endtask
	task automatic t_sag();
		sag_one = 1'b1;
		tick(3);
		check_bit("reset on sag", 1'b1, rst_oe);
		sag_one = 1'b0;
		tick(3);
		check_bit("reset after sag", 1'b0, rst_oe);
	endtask
	task automatic pulse_width(input logic [2:0] duty, output int w);
		int n;
		duty_one = duty;
		tick(3 * PER);
		wait_rise(1, n);
		w = 0;
		while (hs1 === 1'b1 && w < 40) begin
			tick(1);
			w++;
		end
	endtask
	task automatic t_drive();
		int n;
		pulse_width(3'h2, n);
		check_num("duty two eighths", 4, 4, n);
		n = 0;
		while (ls1 !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		check_num("dead time", 7, 9, n);
		pulse_width(3'h7, n);
		check_num("duty ceiling", 13, 14, n);
		wait_rise(1, n);
		wait_rise(2, n);
		check_num("interleave", PER / 2 - 1, PER / 2 + 1, n);
		duty_one = 3'h2;
	endtask
	task automatic check_limit(input logic rail, input logic [11:0] pin,
		input logic [11:0] sense, input logic exp_sw);
		logic seen_hs;
		logic ls_gap;
		at_rail = rail;
		pin_mv = pin;
		sense_mv = sense;
		tick(2 * PER);
		seen_hs = 1'b0;
		ls_gap = 1'b0;
		repeat (4 * PER) begin
			tick(1);
			seen_hs = seen_hs | hs1;
			ls_gap = ls_gap | !ls1;
		end
		check_bit("cycle start", exp_sw, seen_hs);
		check_bit("low side gap", exp_sw, ls_gap);
		sense_mv = 12'h000;
	endtask
	task automatic t_sync();
		int n;
		gap_of(0, n);
		check_num("follower gnd", PER, PER, n);
		sync_tied_rail = 1'b1;
		tick(2 * PER);
		gap_of(0, n);
		check_num("follower rail", PER / 2, PER / 2, n);
		sync_tied_rail = 1'b0;
		sync_run = 1'b1;
		tick(4 * PER);
		check_bit("ext active", 1'b1, ext_on);
		gap_of(1, n);
		check_num("ext switching", PER / 2, PER / 2, n);
		gap_of(0, n);
		check_num("ext follower", PER / 2, PER / 2, n);
		sync_run = 1'b0;
		tick(LOSS + 4 * PER);
		check_bit("fallback", 1'b0, ext_on);
		gap_of(1, n);
		check_num("fallback period", PER, PER, n);
	endtask
	task automatic t_stop();
		int n;
		logic early;
		enable = 1'b0;
		n = 0;
		early = 1'b0;
		while (ref_dac !== 6'h00 && n < SS_CYC + 2 * STEP) begin
			tick(1);
			n++;
			early = early | (hs_to_sw && ref_dac !== 6'h00);
		end
		check_num("soft stop", SS_CYC - 2 * STEP, SS_CYC + STEP, n);
		n = 0;
		while (hs_to_sw !== 1'b1 && n < STEP + PER) begin
			tick(1);
			n++;
		end
		check_bit("early shutdown", 1'b0, early);
		check_bit("shutdown", 1'b1, hs_to_sw);
	endtask
	task automatic t_thermal();
		logic [dbs_pkg::DAC_W-1:0] held;
		enable = 1'b1;
		tick(2 * STEP);
		over_temp = 1'b1;
		tick(3);
		check_bit("hot drives", 1'b0, hs1 | ls1 | hs2 | ls2);
		check_bit("hot reset pin", 1'b1, rst_oe);
		check_bit("hot dac", 1'b1, ref_dac === 6'h00);
		over_temp = 1'b0;
		enable = 1'b0;
		tick(4);
		enable = 1'b1;
		tick(2 * STEP);
		check_bit("restart", 1'b1, ref_dac !== 6'h00);
		held = ref_dac;
		clk_en = 1'b0;
		tick(2 * STEP);
		check_bit("frozen ramp", 1'b1, ref_dac === held);
		clk_en = 1'b1;
		tick(2 * STEP);
		check_bit("thawed ramp", 1'b1, ref_dac !== held);
	endtask
	initial begin
		tick(10);
		srst = 1'b0;
		t_lockout();
		t_shutdown();
		t_soft_start();
		t_sag();
		t_drive();
		check_limit(1'b1, 12'h000, 12'h096, 1'b0);
		check_limit(1'b1, 12'h000, 12'h03C, 1'b1);
		check_limit(1'b0, 12'h3E8, 12'h078, 1'b0);
		check_limit(1'b0, 12'h3E8, 12'h050, 1'b1);
		check_limit(1'b0, 12'hFA0, 12'h190, 1'b0);
		check_limit(1'b0, 12'hFA0, 12'h0FA, 1'b1);
		check_limit(1'b0, 12'h0C8, 12'h028, 1'b1);
		t_sync();
		t_stop();
		t_thermal();
		t_lockout();
		give_verdict();
	end
endmodule
